// [hw/sensor_port_master.sv]
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sensor_port_master #(
    parameter logic [15:0] INPUT_WAKE_CYCLES = sensor_port_pkg::INPUT_WAKE_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Avalon-MM slave
    input  wire logic [1:0]  av_address,
    input  wire logic        av_read,
    input  wire logic        av_write,
    input  wire logic [31:0] av_writedata,
    output logic [31:0]      av_readdata,
    output logic             av_waitrequest,
    // Sensor pins
    output logic             sclk,
    output logic             mosi,
    input  wire logic        miso,
    output logic             port_select_low,
    output logic             sensor_reset,
    output logic             sleep_request_low
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_RST_PULSE = 7'h01,
        ST_RST_WAIT  = 7'h02,
        ST_IDLE      = 7'h04,
        ST_SEL_SETUP = 7'h08,
        ST_SHIFT     = 7'h10,
        ST_BYTE_GAP  = 7'h20,
        ST_SEL_HOLD  = 7'h40
    } engine_state_t;

    typedef struct packed {
        engine_state_t             state;
        logic [15:0]               cnt;
        logic [15:0]               gap_cnt;
        sensor_port_pkg::cmd_kind_t kind;
        logic [6:0]                addr;
        logic [7:0]                wdata;
        logic [11:0]               count;
        logic [11:0]               remaining;
        logic                      pend;
        logic                      rst_req;
        logic                      in_addr;
        logic                      after_addr;
        logic                      prev_write;
        logic                      prev_stream;
        logic                      ready;
        logic                      sel_low;
        logic                      sensor_reset;
        logic                      sleep_low;
        logic [7:0]                rx_data;
        logic                      rx_valid;
        logic [7:0]                tx_data;
        logic                      tx_full;
        logic                      start;
        logic [7:0]                sh_byte;
        logic                      m1;
        logic                      m2;
        logic                      wait_req;
        logic [31:0]               readdata;
        logic [15:0]               since_done;
        logic [15:0]               since_rise;
    } master_state_t;

    master_state_t r;
    master_state_t n;
    logic          sh_done;
    logic [7:0]    sh_rx;
    logic          sclk_w;
    logic          mosi_w;

    function automatic logic is_motion(input logic [6:0] a);
        is_motion = (a == sensor_port_pkg::MOTION_REPORT_ADDR) ||
                    (a == sensor_port_pkg::MOTION_BURST_REPORT_ADDR);
    endfunction : is_motion

    byte_shifter #(
        .HALF_CYCLES (sensor_port_pkg::SCLK_HALF_CYC)
    ) u_shifter (
        .clk       (clk),
        .reset     (reset),
        .start     (r.start),
        .tx_byte   (r.sh_byte),
        .miso_sync (r.m2),
        .sclk      (sclk_w),
        .mosi      (mosi_w),
        .done      (sh_done),
        .rx_byte   (sh_rx)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic        req;
        logic        acc;
        logic        data_ok;
        logic [31:0] word;
        req     = av_read || av_write;
        acc     = req && !r.wait_req;
        data_ok = 1'b0;
        word    = 32'h0000_0000;
        n       = r;
        n.m1    = miso;
        n.m2    = r.m1;
        n.start = 1'b0;
        n.cnt   = (r.cnt != 16'h0000) ? r.cnt - 16'h0001 : r.cnt;
        n.gap_cnt    = (r.gap_cnt != 16'h0000) ? r.gap_cnt - 16'h0001 : r.gap_cnt;
        n.since_done = (r.since_done != 16'hffff) ? r.since_done + 16'h0001 : r.since_done;
        n.since_rise = (r.since_rise != 16'hffff) ? r.since_rise + 16'h0001 : r.since_rise;
        if (sh_done) begin
            n.since_done = 16'h0000;
        end
        // Every access takes exactly one wait cycle; readdata is loaded in it.
        n.wait_req = !(req && r.wait_req);
        unique case (av_address)
            sensor_port_pkg::REG_COMMAND: begin
                word[sensor_port_pkg::CMD_DATA_LSB +: 8]   = r.wdata;
                word[sensor_port_pkg::CMD_ADDR_LSB +: 7]   = r.addr;
                word[sensor_port_pkg::CMD_KIND_LSB +: 2]   = r.kind;
                word[sensor_port_pkg::CMD_COUNT_LSB +: 12] = r.count;
            end
            sensor_port_pkg::REG_STATUS: begin
                word[sensor_port_pkg::STAT_BUSY_BIT]     = r.pend || (r.state != ST_IDLE);
                word[sensor_port_pkg::STAT_RX_VALID_BIT] = r.rx_valid;
                word[sensor_port_pkg::STAT_TX_FREE_BIT]  = !r.tx_full;
                word[sensor_port_pkg::STAT_READY_BIT]    = r.ready;
                word[sensor_port_pkg::STAT_SLEEP_BIT]    = !r.sleep_low;
                word[sensor_port_pkg::STAT_RX_LSB +: 8]  = r.rx_data;
            end
            sensor_port_pkg::REG_DATA: begin
                word[7:0] = r.rx_data;
            end
            sensor_port_pkg::REG_CONTROL: begin
                word[sensor_port_pkg::CTL_SLEEP_BIT] = !r.sleep_low;
            end
        endcase
        n.readdata = word;
        if (acc && av_read && av_address == sensor_port_pkg::REG_DATA) begin
            n.rx_valid = 1'b0;
        end
        if (acc && av_write) begin
            if (av_address == sensor_port_pkg::REG_COMMAND && !r.pend && r.state == ST_IDLE) begin
                n.pend  = 1'b1;
                n.wdata = av_writedata[sensor_port_pkg::CMD_DATA_LSB +: 8];
                n.addr  = av_writedata[sensor_port_pkg::CMD_ADDR_LSB +: 7];
                n.kind  = sensor_port_pkg::cmd_kind_t'(av_writedata[sensor_port_pkg::CMD_KIND_LSB +: 2]);
                n.count = av_writedata[sensor_port_pkg::CMD_COUNT_LSB +: 12];
            end
            if (av_address == sensor_port_pkg::REG_CONTROL) begin
                n.sleep_low = !av_writedata[sensor_port_pkg::CTL_SLEEP_BIT];
                if (av_writedata[sensor_port_pkg::CTL_RESET_BIT]) begin
                    n.rst_req = 1'b1;
                end
            end
        end

        // ------------------------------------------------------------
        // Link engine
        // ------------------------------------------------------------
        unique case (r.state)
            ST_RST_PULSE: begin
                if (r.cnt == 16'h0000) begin
                    n.sensor_reset = 1'b0;
                    n.cnt          = INPUT_WAKE_CYCLES;
                    n.state        = ST_RST_WAIT;
                end
            end
            ST_RST_WAIT: begin
                if (r.cnt == 16'h0000) begin
                    n.ready = 1'b1;
                    n.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (r.rst_req) begin
                    n.rst_req      = 1'b0;
                    n.ready        = 1'b0;
                    n.sensor_reset = 1'b1;
                    n.cnt          = sensor_port_pkg::RESET_PULSE_CYC;
                    n.state        = ST_RST_PULSE;
                end else if (r.pend && r.gap_cnt == 16'h0000 && r.sleep_low) begin
                    // The device port is dead while asleep, so nothing starts then.
                    n.sel_low   = 1'b1;
                    n.in_addr   = 1'b1;
                    n.remaining = (r.count == 12'h000) ? 12'h001 : r.count;
                    n.cnt       = sensor_port_pkg::SEL_SETUP_CYC;
                    n.state     = ST_SEL_SETUP;
                end
            end
            ST_SEL_SETUP: begin
                if (r.cnt == 16'h0000) begin
                    n.start   = 1'b1;
                    n.sh_byte = {!r.kind[0], r.addr};
                    n.state   = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (sh_done && r.in_addr) begin
                    n.in_addr    = 1'b0;
                    n.after_addr = 1'b1;
                    n.state      = ST_BYTE_GAP;
                    if (r.kind[0]) begin
                        n.cnt = is_motion(r.addr) ? sensor_port_pkg::MOTION_ADDR_DATA_CYC
                                                  : sensor_port_pkg::ADDR_DATA_CYC;
                    end else if (r.kind[1]) begin
                        n.cnt = sensor_port_pkg::BYTE_GAP_CYC;
                    end else begin
                        n.cnt = 16'(sensor_port_pkg::SCLK_HALF_CYC);
                    end
                end else if (sh_done) begin
                    // Held until the first data byte has finished, so the gap checks can see its start.
                    n.after_addr = 1'b0;
                    if (r.kind[0]) begin
                        n.rx_data  = sh_rx;
                        n.rx_valid = 1'b1;
                    end
                    if (r.kind[1] && r.remaining != 12'h001) begin
                        n.remaining = r.remaining - 12'h001;
                        n.cnt       = sensor_port_pkg::BYTE_GAP_CYC;
                        n.state     = ST_BYTE_GAP;
                    end else begin
                        n.cnt   = sensor_port_pkg::SEL_HOLD_CYC;
                        n.state = ST_SEL_HOLD;
                    end
                end
            end
            ST_BYTE_GAP: begin
                // Stream bytes also wait for software, so nothing is dropped or overrun.
                unique case (r.kind)
                    sensor_port_pkg::KIND_STREAM_WRITE: data_ok = r.tx_full;
                    sensor_port_pkg::KIND_STREAM_READ:  data_ok = !r.rx_valid;
                    default:                            data_ok = 1'b1;
                endcase
                if (r.cnt == 16'h0000 && data_ok) begin
                    n.start      = 1'b1;
                    n.state      = ST_SHIFT;
                    if (r.kind[0]) begin
                        n.sh_byte = 8'hff;
                    end else if (r.kind[1]) begin
                        n.sh_byte = r.tx_data;
                        n.tx_full = 1'b0;
                    end else begin
                        n.sh_byte = r.wdata;
                    end
                end
            end
            ST_SEL_HOLD: begin
                if (r.cnt == 16'h0000) begin
                    n.sel_low     = 1'b0;
                    n.pend        = 1'b0;
                    n.since_rise  = 16'h0000;
                    n.prev_write  = !r.kind[0];
                    n.prev_stream = r.kind[1];
                    n.state       = ST_IDLE;
                    if (!r.kind[0]) begin
                        n.gap_cnt = sensor_port_pkg::WRITE_GAP_CYC;
                    end else if (r.kind[1]) begin
                        n.gap_cnt = sensor_port_pkg::BURST_EXIT_CYC;
                    end else begin
                        n.gap_cnt = sensor_port_pkg::READ_GAP_CYC;
                    end
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase
        // A byte written by software in the cycle the engine takes one is kept.
        if (acc && av_write && av_address == sensor_port_pkg::REG_DATA) begin
            n.tx_data = av_writedata[7:0];
            n.tx_full = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r              <= '0;
            r.state        <= ST_RST_PULSE;
            r.cnt          <= sensor_port_pkg::RESET_PULSE_CYC;
            r.sensor_reset <= 1'b1;
            r.sleep_low    <= 1'b1;
            r.wait_req     <= 1'b1;
            r.since_done   <= 16'hffff;
            r.since_rise   <= 16'hffff;
        end else begin
            r <= n;
        end
    end

    assign av_readdata       = r.readdata;
    assign av_waitrequest    = r.wait_req;
    assign sclk              = sclk_w;
    assign mosi              = mosi_w;
    assign port_select_low   = !r.sel_low;
    assign sensor_reset      = r.sensor_reset;
    assign sleep_request_low = r.sleep_low;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic req_w;
    assign req_w = av_read || av_write;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    select_setup_a: assert property ($fell(port_select_low) |-> sclk [*3])
        else $error("clock moved too soon after select fell");
    select_hold_a: assert property ($rose(port_select_low) |-> $past(sclk, 1) && $past(sclk, 2) && $past(sclk, 3))
        else $error("select rose too soon after the last clock edge");
    write_gap_a: assert property ($fell(port_select_low) && r.prev_write |-> r.since_rise >= sensor_port_pkg::WRITE_GAP_CYC)
        else $error("command started too soon after a write");
    read_gap_a: assert property ($fell(port_select_low) |-> r.since_rise >= sensor_port_pkg::READ_GAP_CYC)
        else $error("command started too soon after the previous one");
    addr_gap_a: assert property (r.start && r.after_addr && r.kind[0] |-> r.since_done >= sensor_port_pkg::ADDR_DATA_CYC)
        else $error("read data clocked too soon after its address");
    motion_gap_a: assert property (r.start && r.after_addr && r.kind[0] && is_motion(r.addr)
                                   |-> r.since_done >= sensor_port_pkg::MOTION_ADDR_DATA_CYC)
        else $error("motion read data clocked too soon after its address");
    byte_gap_a: assert property (r.start && !r.in_addr && r.kind[1] |-> r.since_done >= sensor_port_pkg::BYTE_GAP_CYC)
        else $error("stream bytes too close together");
    burst_exit_a: assert property ($fell(port_select_low) && r.prev_stream
                                   |-> r.since_rise >= sensor_port_pkg::BURST_EXIT_CYC)
        else $error("select not high long enough after a stream");
    reset_quiet_a: assert property (r.state == ST_RST_PULSE || r.state == ST_RST_WAIT |-> port_select_low && sclk)
        else $error("link active during device reset wait");
    frame_dir_a: assert property (r.start && r.in_addr |=> mosi == !r.kind[0])
        else $error("address byte carries the wrong direction bit");
    bus_answer_a: assert property (req_w && av_waitrequest |=> !av_waitrequest)
        else $error("bus access not answered in one cycle");

endmodule : sensor_port_master
`default_nettype wire

// [hw/sensor_port_pkg.sv]
// Contract
// - Leave at least 50 us between the final data-bit rising edges of two writes.
// - Leave at least 50 us from a write's last data rise to a read's last address rise.
// - After a read, wait 250 ns before the next command's first address falling edge.
// - Ordinary register reads need 50 us between address and data byte.
// - Reads of addresses 0x02 and 0x50 need 75 us between address and data.
// - Select must be low 120 ns before the first rising clock edge.
// - Select must stay low 120 ns after the final falling clock edge.
// - Firmware download and frame capture bytes are spaced at least 10 us apart.
// - Select stays high at least 4 us to leave burst mode.
// - No transaction during the 500 us after the device reset falls.
// - A write is an address byte with MSB one, then a data byte.
// - A read is an address byte with MSB zero, then a returned data byte.
package sensor_port_pkg;

    // ----------------------------------------------------------------
    // Timing, in nanoseconds as specified and in clock cycles
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS       = 50;
    localparam int unsigned WRITE_GAP_NS        = 50000;
    localparam int unsigned READ_GAP_NS         = 250;
    localparam int unsigned ADDR_DATA_NS        = 50000;
    localparam int unsigned MOTION_ADDR_DATA_NS = 75000;
    localparam int unsigned SEL_SETUP_NS        = 120;
    localparam int unsigned SEL_HOLD_NS         = 120;
    localparam int unsigned BYTE_GAP_NS         = 10000;
    localparam int unsigned BURST_EXIT_NS       = 4000;
    localparam int unsigned INPUT_WAKE_NS       = 500000;
    localparam int unsigned RESET_PULSE_NS      = 10000;

    localparam logic [15:0] WRITE_GAP_CYC        = 16'((WRITE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] READ_GAP_CYC         = 16'((READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] ADDR_DATA_CYC        = 16'((ADDR_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] MOTION_ADDR_DATA_CYC = 16'((MOTION_ADDR_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] SEL_SETUP_CYC        = 16'((SEL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] SEL_HOLD_CYC         = 16'((SEL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] BYTE_GAP_CYC         = 16'((BYTE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] BURST_EXIT_CYC       = 16'((BURST_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] INPUT_WAKE_CYC       = 16'((INPUT_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] RESET_PULSE_CYC      = 16'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int unsigned SCLK_HALF_CYC        = 10;

    // ----------------------------------------------------------------
    // Register map, word indices on the bus
    // ----------------------------------------------------------------
    localparam logic [1:0] REG_COMMAND = 2'h0;
    localparam logic [1:0] REG_STATUS  = 2'h1;
    localparam logic [1:0] REG_DATA    = 2'h2;
    localparam logic [1:0] REG_CONTROL = 2'h3;

    localparam int unsigned CMD_DATA_LSB       = 0;
    localparam int unsigned CMD_ADDR_LSB       = 8;
    localparam int unsigned CMD_KIND_LSB       = 16;
    localparam int unsigned CMD_COUNT_LSB      = 18;
    localparam int unsigned STAT_BUSY_BIT      = 0;
    localparam int unsigned STAT_RX_VALID_BIT  = 1;
    localparam int unsigned STAT_TX_FREE_BIT   = 2;
    localparam int unsigned STAT_READY_BIT     = 3;
    localparam int unsigned STAT_SLEEP_BIT     = 4;
    localparam int unsigned STAT_RX_LSB        = 8;
    localparam int unsigned CTL_SLEEP_BIT      = 0;
    localparam int unsigned CTL_RESET_BIT      = 1;

    // ----------------------------------------------------------------
    // Device addresses and command kinds
    // ----------------------------------------------------------------
    localparam logic [6:0] MOTION_REPORT_ADDR       = 7'h02;
    localparam logic [6:0] MOTION_BURST_REPORT_ADDR = 7'h50;

    typedef enum logic [1:0] {
        KIND_WRITE        = 2'h0,
        KIND_READ         = 2'h1,
        KIND_STREAM_WRITE = 2'h2,
        KIND_STREAM_READ  = 2'h3
    } cmd_kind_t;

endpackage : sensor_port_pkg

// [hw/byte_shifter.sv]
`timescale 1ns/10ps
`default_nettype none
module byte_shifter #(
    parameter int unsigned HALF_CYCLES = sensor_port_pkg::SCLK_HALF_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Byte request
    input  wire logic       start,
    input  wire logic [7:0] tx_byte,
    input  wire logic       miso_sync,
    // Serial pins and result
    output logic            sclk,
    output logic            mosi,
    output logic            done,
    output logic [7:0]      rx_byte
);
    typedef struct packed {
        logic       busy;
        logic [7:0] cnt;
        logic [2:0] bitn;
        logic [7:0] sh;
        logic       sclk;
        logic       mosi;
        logic       done;
    } shifter_state_t;

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

    shifter_state_t r;
    shifter_state_t n;

    always_comb begin
        n      = r;
        n.done = 1'b0;
        if (!r.busy) begin
            if (start) begin
                n.busy = 1'b1;
                n.sh   = tx_byte;
                n.sclk = 1'b0;
                n.mosi = tx_byte[7];
                n.cnt  = HALF_LAST;
                n.bitn = 3'h0;
            end
        end else if (r.cnt != 8'h00) begin
            n.cnt = r.cnt - 8'h01;
        end else if (!r.sclk) begin
            n.sclk = 1'b1;
            n.sh   = {r.sh[6:0], miso_sync};
            n.cnt  = HALF_LAST;
            if (r.bitn == 3'h7) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end else begin
                n.bitn = r.bitn + 3'h1;
            end
        end else begin
            n.sclk = 1'b0;
            n.mosi = r.sh[7];
            n.cnt  = HALF_LAST;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r      <= '0;
            r.sclk <= 1'b1;
            r.mosi <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign sclk    = r.sclk;
    assign mosi    = r.mosi;
    assign done    = r.done;
    assign rx_byte = r.sh;

endmodule : byte_shifter
`default_nettype wire

// [tb/sensor_model.sv]
`timescale 1ns/10ps
`default_nettype none
module sensor_model (
    // Serial pins
    input  wire logic  sclk,
    input  wire logic  mosi,
    input  wire logic  port_select_low,
    output logic       miso,
    // Observation
    output logic [7:0] last_write,
    output int         gap_err
);
    logic [7:0] regs [0:127];
    logic [7:0] sh;
    logic [7:0] ab;
    int         n;
    realtime    t_addr;
    realtime    t_wr;
    realtime    t_byte;
    initial begin
        miso = 1'b0;
        n = 0;
        gap_err = 0;
        t_wr = -1.0e6;
        // Contents are valid from the start, so the model never serves stale motion data.
        for (int i = 0; i < 128; i++) regs[i] = 8'(i) ^ 8'h5a;
    end
    // A released line shows the inverse of its last bit, so late sampling is caught.
    always @(posedge port_select_low) begin
        n = 0;
        #100 miso = ~miso;
    end
    always @(posedge sclk) if (!port_select_low) begin
        sh = {sh[6:0], mosi};
        n++;
        if (n % 8 == 0) t_byte = $realtime;
        if (n == 8) begin
            ab = sh;
            t_addr = $realtime;
            if (!sh[7] && $realtime - t_wr < 50000.0) gap_err++;
        end
        if (n == 16 && ab[7]) begin
            if ($realtime - t_wr < 50000.0) gap_err++;
            regs[ab[6:0]] = sh;
            t_wr = $realtime;
        end
        if (n >= 16 && n % 8 == 0 && ab[7]) last_write = sh;
    end
    // Stream reads run on through the map, one register per byte.
    always @(negedge sclk) if (!port_select_low) begin
        if (n >= 16 && n % 8 == 0 && $realtime - t_byte < 10000.0) gap_err++;
        if (n >= 8 && !ab[7]) begin
            if (n == 8 && $realtime - t_addr < ((ab[6:0] == 7'h02 || ab[6:0] == 7'h50) ? 75000.0 : 50000.0))
                gap_err++;
            miso = regs[ab[6:0] + 7'((n - 8) / 8)][7 - n % 8];
        end
    end
endmodule : sensor_model
`default_nettype wire

// [tb/motion_sensor_port_timing_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module motion_sensor_port_timing_tb;
    logic clk, reset, av_read, av_write, av_waitrequest, sclk, mosi, miso, port_select_low, sensor_reset;
    logic sleep_request_low;
    logic [1:0] av_address;
    logic [31:0] av_writedata, av_readdata, q;
    logic [7:0] last_write;
    int gap_err, n_errors, cmp_count;
    sensor_port_master #(.INPUT_WAKE_CYCLES(16'h0014)) dut (.clk(clk), .reset(reset),
        .av_address(av_address), .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
        .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .sclk(sclk), .mosi(mosi), .miso(miso),
        .port_select_low(port_select_low), .sensor_reset(sensor_reset), .sleep_request_low(sleep_request_low));
    sensor_model model (.sclk(sclk), .mosi(mosi), .port_select_low(port_select_low), .miso(miso),
        .last_write(last_write), .gap_err(gap_err));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Registered outputs read right after the edge still show the sampled value.
    task automatic acc(input logic w, input logic [1:0] a, input logic [31:0] d);
        @(posedge clk);
        av_address <= a;
        av_write <= w;
        av_read <= ~w;
        av_writedata <= d;
        do @(posedge clk);
        while (av_waitrequest !== 1'b0);
        q = av_readdata;
        av_write <= 1'b0;
        av_read <= 1'b0;
    endtask : acc
    // Waits end when the status bit matches, or else at the watchdog, which then closes the run as a failure.
    task automatic poll(input int b, input logic v);
        do acc(1'b0, sensor_port_pkg::REG_STATUS, 32'h0);
        while (q[b] !== v);
    endtask : poll
    task automatic summarize();
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #2000000;
        n_errors++;
        summarize();
    end
    initial begin
        {n_errors, cmp_count} = '0;
        {reset, av_read, av_write, av_address, av_writedata} = {1'b1, 36'h0};
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        chk({31'h0, sensor_reset}, 32'h1);
        poll(sensor_port_pkg::STAT_READY_BIT, 1'b1);
        chk({31'h0, sensor_reset}, 32'h0);
        acc(1'b1, sensor_port_pkg::REG_COMMAND, 32'h0000_10a5);
        poll(sensor_port_pkg::STAT_BUSY_BIT, 1'b0);
        chk({24'h0, last_write}, 32'h0000_00a5);
        $display("write done");
        // Read back 0x10, then the motion register, whose model value is its address xor 0x5a.
        acc(1'b1, sensor_port_pkg::REG_COMMAND, 32'h0001_1000);
        poll(sensor_port_pkg::STAT_RX_VALID_BIT, 1'b1);
        acc(1'b0, sensor_port_pkg::REG_DATA, 32'h0);
        chk(q & 32'hff, 32'h0000_00a5);
        acc(1'b1, sensor_port_pkg::REG_COMMAND, 32'h0001_0200);
        poll(sensor_port_pkg::STAT_RX_VALID_BIT, 1'b1);
        acc(1'b0, sensor_port_pkg::REG_DATA, 32'h0);
        chk(q & 32'hff, 32'h0000_0058);
        chk(32'(gap_err), 32'h0);
        $display("read done");
        // Two-byte stream write to 0x20, then a two-byte stream read from 0x30.
        acc(1'b1, sensor_port_pkg::REG_COMMAND, 32'h000a_2000);
        acc(1'b1, sensor_port_pkg::REG_DATA, 32'h0000_0011);
        poll(sensor_port_pkg::STAT_TX_FREE_BIT, 1'b1);
        acc(1'b1, sensor_port_pkg::REG_DATA, 32'h0000_0022);
        poll(sensor_port_pkg::STAT_BUSY_BIT, 1'b0);
        chk({24'h0, last_write}, 32'h0000_0022);
        acc(1'b1, sensor_port_pkg::REG_COMMAND, 32'h000b_3000);
        for (int i = 0; i < 2; i++) begin
            poll(sensor_port_pkg::STAT_RX_VALID_BIT, 1'b1);
            acc(1'b0, sensor_port_pkg::REG_DATA, 32'h0);
            chk(q & 32'hff, 32'h0000_006a + i);
        end
        chk(32'(gap_err), 32'h0);
        $display("stream done");
        acc(1'b1, sensor_port_pkg::REG_CONTROL, 32'h1);
        poll(sensor_port_pkg::STAT_SLEEP_BIT, 1'b1);
        chk({31'h0, sleep_request_low}, 32'h0);
        $display("sleep done");
        summarize();
    end
endmodule : motion_sensor_port_timing_tb
`default_nettype wire
